// ### design/rxp_cfg_map.vh
`ifndef RXP_CFG_MAP_VH
`define RXP_CFG_MAP_VH

// register offsets
`define RXP_OFF_PORT_SEL      8'h4C
`define RXP_OFF_TGT_ID6       8'h5D
`define RXP_OFF_TGT_ID7       8'h5E
`define RXP_OFF_ALIAS6        8'h6B
`define RXP_OFF_ALIAS7        8'h6C
`define RXP_OFF_PORT_CFG      8'h6D
`define RXP_OFF_BC_GPIO0      8'h6E

// reset values
`define RXP_RST_PORT_SEL      8'h10
`define RXP_RST_TGT_ID        8'h00
`define RXP_RST_ALIAS         8'h00
`define RXP_RST_PORT_CFG_HI   6'h1E
`define RXP_RST_BC_GPIO       8'h88

// port select fields
`define RXP_PSEL_RD_LSB       0
`define RXP_PSEL_WR_LSB       4

// alias register fields
`define RXP_ALIAS_ADDR_MSB    7
`define RXP_ALIAS_ADDR_LSB    1
`define RXP_ALIAS_ACK_BIT     0

// port config fields
`define RXP_CFG_WAIT_FS1_BIT  7
`define RXP_CFG_WAIT_FS_BIT   6
`define RXP_CFG_FWD_CKSUM_BIT 5
`define RXP_CFG_FWD_ECC_BIT   4
`define RXP_CFG_LEN_LINE_BIT  3
`define RXP_CFG_MODE_MSB      1
`define RXP_CFG_MODE_LSB      0

// link input modes
`define RXP_MODE_CSI2         2'h0
`define RXP_MODE_RAW12_LF     2'h1
`define RXP_MODE_RAW12_HF     2'h2
`define RXP_MODE_RAW10        2'h3

// back-channel source codes
`define RXP_BC_CONST0         4'h8
`define RXP_BC_CONST1         4'h9
`define RXP_BC_FSYNC          4'hA

// frame count that releases the first-frame wait
`define RXP_FIRST_FRAME_CNT   16'h0001

`endif

// ### design/rxp_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "rxp_cfg_map.vh"

// Overview of operation
// - each slot holds 7-bit alias; matching I2C address remapped to slot target ID.
// - alias field of zero disables that slot; no forwarding through it.
// - auto-ack bit set acknowledges every write to that target, lock-independent.
// - every receive port keeps its own copy; port select chooses accessed copy.
// - wait-first-frame bit rejects packets until Frame Start with count 1.
// - wait-frame-start bit rejects packets until any Frame Start arrives.
// - checksum-errored packets forwarded when bit 5 set, dropped when clear.
// - header-ECC-errored packets forwarded when bit 4 set, dropped when clear.
// - in RAW modes both wait bits and checksum bit are ignored.
// - RAW mode bit 3 set discards truncated first line, clear forwards it.
// - CSI-2 mode bit 3 set forwards length-errored packets, clear drops them.
// - two-bit input mode loads from strap on the first edge after reset release, writable afterwards.
// - select code with MSB 0 sends local pin GPIOx, x from low bits.
// - codes 1000 zero, 1001 one, 1010 frame sync; higher codes reserved.
// - GPIO1 selector bits 7:4, GPIO0 bits 3:0, each resetting to 0x8.
module rxp_cfg #(
	parameter NUM_PORTS = 4,
	parameter DATA_W    = 8
) (
	input  wire                     core_clk,
	input  wire                     rstn,
	input  wire [2*NUM_PORTS-1:0]   mode_strap,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	input  wire [7:0]               reg_addr,
	input  wire [7:0]               reg_wdata,
	output reg  [7:0]               reg_rdata_r,
	output reg                      reg_rvalid_r,
	input  wire                     i2c_addr_vld,
	input  wire [6:0]               i2c_addr,
	input  wire                     i2c_is_write,
	output reg                      fwd_vld_r,
	output reg                      fwd_hit_r,
	output reg  [1:0]               fwd_port_r,
	output reg  [6:0]               fwd_addr_r,
	output reg                      auto_ack_r,
	input  wire                     pkt_valid,
	input  wire                     pkt_sop,
	input  wire                     pkt_eop,
	input  wire [1:0]               pkt_port,
	input  wire [DATA_W-1:0]        pkt_data,
	input  wire                     pkt_is_fs,
	input  wire [15:0]              pkt_frame_cnt,
	input  wire                     pkt_cksum_err,
	input  wire                     pkt_ecc_err,
	input  wire                     pkt_len_err,
	input  wire                     pkt_trunc_line,
	output reg                      out_valid_r,
	output reg                      out_sop_r,
	output reg                      out_eop_r,
	output reg  [1:0]               out_port_r,
	output reg  [DATA_W-1:0]        out_data_r,
	input  wire [7:0]               gpio_local,
	input  wire                     frame_sync_pulse,
	output reg  [2*NUM_PORTS-1:0]   bc_gpio_r
);

	// reset release through two flops, assertion stays asynchronous
	reg rst_meta_r;
	reg rst_n_r;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// per-port register copies, plus the shared port select and the strap-done flag
	reg [7:0] port_sel_r;
	reg [7:0] tgt_id6_r  [0:NUM_PORTS-1];
	reg [7:0] tgt_id7_r  [0:NUM_PORTS-1];
	reg [7:0] alias6_r   [0:NUM_PORTS-1];
	reg [7:0] alias7_r   [0:NUM_PORTS-1];
	reg [7:0] port_cfg_r [0:NUM_PORTS-1];
	reg [7:0] bc_gpio0_r [0:NUM_PORTS-1];
	reg       strap_done_r;

	wire [1:0]           rd_port  = port_sel_r[`RXP_PSEL_RD_LSB+1:`RXP_PSEL_RD_LSB];
	wire [NUM_PORTS-1:0] wr_mask  = port_sel_r[`RXP_PSEL_WR_LSB+NUM_PORTS-1:`RXP_PSEL_WR_LSB];

	// register writes fan out to every port enabled in the write mask
	integer wp;
	always @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			port_sel_r   <= `RXP_RST_PORT_SEL;
			strap_done_r <= 1'b0;
			for (wp = 0; wp < NUM_PORTS; wp = wp + 1) begin
				tgt_id6_r[wp]  <= `RXP_RST_TGT_ID;
				tgt_id7_r[wp]  <= `RXP_RST_TGT_ID;
				alias6_r[wp]   <= `RXP_RST_ALIAS;
				alias7_r[wp]   <= `RXP_RST_ALIAS;
				port_cfg_r[wp] <= {`RXP_RST_PORT_CFG_HI, 2'h0};
				bc_gpio0_r[wp] <= `RXP_RST_BC_GPIO;
			end
		end else begin
			strap_done_r <= 1'b1;
			// strap caught on the first edge after release, not by the reset itself
			if (!strap_done_r) begin
				for (wp = 0; wp < NUM_PORTS; wp = wp + 1) begin
					port_cfg_r[wp][`RXP_CFG_MODE_MSB:`RXP_CFG_MODE_LSB] <= mode_strap[2*wp +: 2];
				end
			end else if (reg_wr) begin
				if (reg_addr == `RXP_OFF_PORT_SEL) begin
					port_sel_r <= reg_wdata;
				end
				for (wp = 0; wp < NUM_PORTS; wp = wp + 1) begin
					if (wr_mask[wp]) begin
						case (reg_addr)
							`RXP_OFF_TGT_ID6: tgt_id6_r[wp] <= {1'b0, reg_wdata[6:0]};
							`RXP_OFF_TGT_ID7: tgt_id7_r[wp] <= {1'b0, reg_wdata[6:0]};
							`RXP_OFF_ALIAS6: alias6_r[wp] <= reg_wdata;
							`RXP_OFF_ALIAS7: alias7_r[wp] <= reg_wdata;
							// bit 2 is reserved and stays zero
							`RXP_OFF_PORT_CFG: port_cfg_r[wp] <= {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
							`RXP_OFF_BC_GPIO0: bc_gpio0_r[wp] <= reg_wdata;
							default: ;
						endcase
					end
				end
			end
		end
	end

	// read data from the port chosen by the read index, unmapped reads zero
	always @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata_r  <= 8'h00;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					`RXP_OFF_PORT_SEL: reg_rdata_r <= port_sel_r;
					`RXP_OFF_TGT_ID6:  reg_rdata_r <= tgt_id6_r[rd_port];
					`RXP_OFF_TGT_ID7:  reg_rdata_r <= tgt_id7_r[rd_port];
					`RXP_OFF_ALIAS6:   reg_rdata_r <= alias6_r[rd_port];
					`RXP_OFF_ALIAS7:   reg_rdata_r <= alias7_r[rd_port];
					`RXP_OFF_PORT_CFG: reg_rdata_r <= port_cfg_r[rd_port];
					`RXP_OFF_BC_GPIO0: reg_rdata_r <= bc_gpio0_r[rd_port];
					default:           reg_rdata_r <= 8'h00;
				endcase
			end
		end
	end

	// alias search: lowest port first, slot 6 before slot 7
	reg       hit_nxt;
	reg [1:0] hit_port_nxt;
	reg [6:0] hit_addr_nxt;
	reg       hit_ack_nxt;
	integer   ap;
	always @* begin
		hit_nxt      = 1'b0;
		hit_port_nxt = 2'h0;
		hit_addr_nxt = 7'h00;
		hit_ack_nxt  = 1'b0;
		for (ap = NUM_PORTS - 1; ap >= 0; ap = ap - 1) begin
			// a zero alias never matches, which closes the slot
			if (alias7_r[ap][7:1] != 7'h00 && alias7_r[ap][7:1] == i2c_addr) begin
				hit_nxt      = 1'b1;
				hit_port_nxt = ap[1:0];
				hit_addr_nxt = tgt_id7_r[ap][6:0];
				hit_ack_nxt  = alias7_r[ap][`RXP_ALIAS_ACK_BIT];
			end
			if (alias6_r[ap][7:1] != 7'h00 && alias6_r[ap][7:1] == i2c_addr) begin
				hit_nxt      = 1'b1;
				hit_port_nxt = ap[1:0];
				hit_addr_nxt = tgt_id6_r[ap][6:0];
				hit_ack_nxt  = alias6_r[ap][`RXP_ALIAS_ACK_BIT];
			end
		end
	end

	// remap result, one cycle after the address is offered
	always @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fwd_vld_r  <= 1'b0;
			fwd_hit_r  <= 1'b0;
			fwd_port_r <= 2'h0;
			fwd_addr_r <= 7'h00;
			auto_ack_r <= 1'b0;
		end else begin
			fwd_vld_r <= i2c_addr_vld;
			if (i2c_addr_vld) begin
				fwd_hit_r  <= hit_nxt;
				fwd_port_r <= hit_port_nxt;
				fwd_addr_r <= hit_addr_nxt;
				// no link-lock term here on purpose: the ack must not depend on it
				auto_ack_r <= hit_nxt & hit_ack_nxt & i2c_is_write;
			end else begin
				auto_ack_r <= 1'b0;
			end
		end
	end

	// admission decision for the packet starting now
	wire [7:0] cfg_cur = port_cfg_r[pkt_port];
	wire       raw_mode = (cfg_cur[`RXP_CFG_MODE_MSB:`RXP_CFG_MODE_LSB] != `RXP_MODE_CSI2);
	wire       is_fs1   = pkt_is_fs && (pkt_frame_cnt == `RXP_FIRST_FRAME_CNT);
	reg  [NUM_PORTS-1:0] seen_fs_r;
	reg  [NUM_PORTS-1:0] seen_fs1_r;
	reg        admit_nxt;
	always @* begin
		admit_nxt = 1'b1;
		if (raw_mode) begin
			// wait and checksum bits have no say here
			if (pkt_trunc_line && cfg_cur[`RXP_CFG_LEN_LINE_BIT])
				admit_nxt = 1'b0;
		end else begin
			if (cfg_cur[`RXP_CFG_WAIT_FS1_BIT] && !seen_fs1_r[pkt_port] && !is_fs1)
				admit_nxt = 1'b0;
			if (cfg_cur[`RXP_CFG_WAIT_FS_BIT] && !seen_fs_r[pkt_port] && !pkt_is_fs)
				admit_nxt = 1'b0;
			if (pkt_cksum_err && !cfg_cur[`RXP_CFG_FWD_CKSUM_BIT])
				admit_nxt = 1'b0;
			if (pkt_len_err && !cfg_cur[`RXP_CFG_LEN_LINE_BIT])
				admit_nxt = 1'b0;
		end
		if (pkt_ecc_err && !cfg_cur[`RXP_CFG_FWD_ECC_BIT])
			admit_nxt = 1'b0;
	end

	// decision taken at start of packet and held to its end, so drops are whole
	reg pass_r;
	always @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pass_r      <= 1'b0;
			seen_fs_r   <= {NUM_PORTS{1'b0}};
			seen_fs1_r  <= {NUM_PORTS{1'b0}};
			out_valid_r <= 1'b0;
			out_sop_r   <= 1'b0;
			out_eop_r   <= 1'b0;
			out_port_r  <= 2'h0;
			out_data_r  <= {DATA_W{1'b0}};
		end else begin
			out_valid_r <= 1'b0;
			out_sop_r   <= 1'b0;
			out_eop_r   <= 1'b0;
			if (pkt_valid && pkt_sop) begin
				pass_r <= admit_nxt & ~pkt_eop;
				if (pkt_is_fs)
					seen_fs_r[pkt_port] <= 1'b1;
				if (is_fs1)
					seen_fs1_r[pkt_port] <= 1'b1;
				if (admit_nxt) begin
					out_valid_r <= 1'b1;
					out_sop_r   <= 1'b1;
					out_eop_r   <= pkt_eop;
					out_port_r  <= pkt_port;
					out_data_r  <= pkt_data;
				end
			end else if (pkt_valid && pass_r) begin
				// beats pass unchanged; a late error flag cannot cut a packet short
				out_valid_r <= 1'b1;
				out_eop_r   <= pkt_eop;
				out_data_r  <= pkt_data;
				if (pkt_eop)
					pass_r <= 1'b0;
			end else if (pkt_valid && pkt_eop) begin
				pass_r <= 1'b0;
			end
		end
	end

	// back-channel source per port; reserved codes send zero
	function bc_src;
		input [3:0] sel;
		input [7:0] pins;
		input       fsync;
		begin
			if (!sel[3])
				bc_src = pins[sel[2:0]];
			else if (sel == `RXP_BC_CONST1)
				bc_src = 1'b1;
			else if (sel == `RXP_BC_FSYNC)
				bc_src = fsync;
			else
				bc_src = 1'b0;
		end
	endfunction

	integer gp;
	always @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			bc_gpio_r <= {2*NUM_PORTS{1'b0}};
		end else begin
			for (gp = 0; gp < NUM_PORTS; gp = gp + 1) begin
				bc_gpio_r[2*gp]   <= bc_src(bc_gpio0_r[gp][3:0], gpio_local, frame_sync_pulse);
				bc_gpio_r[2*gp+1] <= bc_src(bc_gpio0_r[gp][7:4], gpio_local, frame_sync_pulse);
			end
		end
	end

endmodule
`default_nettype wire

// ### tb/rxp_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rxp_cfg_sva #(parameter DATA_W = 8) (
	input wire logic              core_clk,
	input wire logic              rstn,
	input wire logic              reg_rd,
	input wire logic              reg_rvalid_r,
	input wire logic              i2c_addr_vld,
	input wire logic [6:0]        i2c_addr,
	input wire logic              i2c_is_write,
	input wire logic              fwd_vld_r,
	input wire logic              fwd_hit_r,
	input wire logic [6:0]        fwd_addr_r,
	input wire logic              auto_ack_r,
	input wire logic              pkt_valid,
	input wire logic              pkt_sop,
	input wire logic [DATA_W-1:0] pkt_data,
	input wire logic              out_valid_r,
	input wire logic              out_sop_r,
	input wire logic [DATA_W-1:0] out_data_r
);
	// single domain, so one default clock and reset serve every property
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// register and lookup answers land exactly one cycle after the request
	a_read_answer: assert property (reg_rvalid_r == $past(reg_rd)) else $error("read answer off");
	a_lookup_answer: assert property (fwd_vld_r == $past(i2c_addr_vld)) else $error("lookup late");
	a_result_holds: assert property (!fwd_vld_r |-> $stable(fwd_addr_r) && $stable(fwd_hit_r)) else $error("result moved");
	a_zero_no_hit: assert property (i2c_addr_vld && i2c_addr == 7'h00 |=> !fwd_hit_r) else $error("zero alias hit");
	a_ack_on_write: assert property (auto_ack_r |-> fwd_hit_r && $past(i2c_is_write)) else $error("bad auto ack");
	a_no_read_ack: assert property (i2c_addr_vld && !i2c_is_write |=> !auto_ack_r) else $error("read acked");
	// an output beat always has a beat one cycle earlier behind it, untouched
	a_beat_source: assert property (out_valid_r |-> $past(pkt_valid)) else $error("beat from nowhere");
	a_beat_copy: assert property (out_valid_r |-> out_data_r == $past(pkt_data) && out_sop_r == $past(pkt_sop))
		else $error("beat altered");
	cover property (auto_ack_r);
	cover property (fwd_vld_r && !fwd_hit_r);
	cover property (out_valid_r && out_sop_r);
endmodule
bind rxp_cfg rxp_cfg_sva #(.DATA_W(DATA_W)) rxp_cfg_sva_i (.core_clk(core_clk), .rstn(rstn), .reg_rd(reg_rd),
	.reg_rvalid_r(reg_rvalid_r), .i2c_addr_vld(i2c_addr_vld), .i2c_addr(i2c_addr), .i2c_is_write(i2c_is_write),
	.fwd_vld_r(fwd_vld_r), .fwd_hit_r(fwd_hit_r), .fwd_addr_r(fwd_addr_r), .auto_ack_r(auto_ack_r),
	.pkt_valid(pkt_valid), .pkt_sop(pkt_sop), .pkt_data(pkt_data), .out_valid_r(out_valid_r),
	.out_sop_r(out_sop_r), .out_data_r(out_data_r));
`default_nettype wire

// ### tb/rxp_ser_model.sv
`timescale 1ns/1ps
`default_nettype none
module rxp_ser_model (
	input wire logic        core_clk,
	output var logic        pkt_valid,
	output var logic        pkt_sop,
	output var logic        pkt_eop,
	output var logic [1:0]  pkt_port,
	output var logic [7:0]  pkt_data,
	output var logic [4:0]  pkt_flags,
	output var logic [15:0] pkt_cnt
);
	// idle link; flags are fs, checksum, ecc, length, truncated line
	initial begin
		pkt_valid = 1'b0;
		pkt_sop = 1'b0;
		pkt_eop = 1'b0;
		pkt_port = 2'h0;
		pkt_data = 8'h00;
		pkt_flags = 5'h00;
		pkt_cnt = 16'h0000;
	end
	// data shows the inverse once released, so a stale byte never looks valid
	task automatic send(input logic [1:0] p, input logic [4:0] f, input logic [15:0] c, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			pkt_valid <= 1'b1;
			pkt_sop <= (i == 0);
			pkt_eop <= (i == n - 1);
			pkt_port <= p;
			pkt_flags <= f;
			pkt_cnt <= c;
			pkt_data <= 8'h30 + i[7:0];
		end
		@(posedge core_clk);
		pkt_valid <= 1'b0;
		pkt_sop <= 1'b0;
		pkt_eop <= 1'b0;
		pkt_data <= ~pkt_data;
	endtask
endmodule
`default_nettype wire

// ### tb/rx_port_link_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module rx_port_link_config_test;
	logic        core_clk, rstn, reg_wr, reg_rd, i2c_addr_vld, i2c_is_write, fsync;
	logic [7:0]  reg_addr, reg_wdata, rdata, bc, odata, pd;
	logic [6:0]  i2c_addr, faddr;
	logic [1:0]  fport, oport, pp;
	logic        rvld, fvld, fhit, fack, ov, os, oe, pv, ps, pe;
	logic [4:0]  pf;
	logic [15:0] pc;
	int          num_errors, n_compared, beats;
	logic [10:0] last;
	rxp_cfg rxp_cfg_i (.core_clk(core_clk), .rstn(rstn), .mode_strap(8'h70), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rvld),
		.i2c_addr_vld(i2c_addr_vld), .i2c_addr(i2c_addr), .i2c_is_write(i2c_is_write), .fwd_vld_r(fvld),
		.fwd_hit_r(fhit), .fwd_port_r(fport), .fwd_addr_r(faddr), .auto_ack_r(fack), .pkt_valid(pv),
		.pkt_sop(ps), .pkt_eop(pe), .pkt_port(pp), .pkt_data(pd), .pkt_is_fs(pf[4]), .pkt_frame_cnt(pc),
		.pkt_cksum_err(pf[3]), .pkt_ecc_err(pf[2]), .pkt_len_err(pf[1]), .pkt_trunc_line(pf[0]),
		.out_valid_r(ov), .out_sop_r(os), .out_eop_r(oe), .out_port_r(oport), .out_data_r(odata),
		.gpio_local(8'hA5), .frame_sync_pulse(fsync), .bc_gpio_r(bc));
	rxp_ser_model rxp_ser_model_i (.core_clk(core_clk), .pkt_valid(pv), .pkt_sop(ps), .pkt_eop(pe),
		.pkt_port(pp), .pkt_data(pd), .pkt_flags(pf), .pkt_cnt(pc));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// every forwarded beat, counted at the edge that ends it
	// last forwarded beat kept as port, end flag and data for the packet check
	always @(posedge core_clk) begin
		if (ov === 1'b1) begin
			beats++;
			last = {oport, oe, odata};
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk({rvld, rdata}, {1'b1, exp});
	endtask
	// target address is only meaningful on a hit, so it is judged only then
	task automatic look(input logic [6:0] a, input logic w, input logic h, input logic [6:0] t, input logic k);
		@(posedge core_clk);
		i2c_addr_vld <= 1'b1;
		i2c_addr <= a;
		i2c_is_write <= w;
		@(posedge core_clk);
		i2c_addr_vld <= 1'b0;
		#1 chk({fvld, fhit, fack}, {1'b1, h, k});
		if (h) chk({fport, faddr}, {2'h0, t});
	endtask
	task automatic pkt(input logic [1:0] p, input logic [4:0] f, input logic [15:0] c, input int n, input int e);
		int b0;
		b0 = beats;
		rxp_ser_model_i.send(p, f, c, n);
		repeat (3) @(posedge core_clk);
		chk(beats - b0, e);
		if (e > 0) chk(last, {p, 1'b1, 8'h30 + n[7:0] - 8'h01});
	endtask
	task automatic t_regs;
		chk(bc, 8'h00);
		rd(8'h6C, 8'h00);
		rd(8'h6D, 8'h78);
		rd(8'h6E, 8'h88);
		rd(8'h7F, 8'h00);
		wr(8'h4C, 8'h20);
		wr(8'h6E, 8'h9A);
		rd(8'h6E, 8'h88);
		wr(8'h4C, 8'h21);
		rd(8'h6E, 8'h9A);
		wr(8'h6D, 8'h7A);
		rd(8'h6D, 8'h7A);
		wr(8'h6D, 8'h78);
		wr(8'h4C, 8'h12);
		rd(8'h6D, 8'h7B);
		$display("t_regs done");
	endtask
	task automatic t_gpio;
		logic e;
		logic [7:0] gl;
		gl = 8'hA5;
		// frame sync low while its code is tested, so a constant one cannot pass
		for (int c = 0; c < 12; c++) begin
			fsync <= c[0];
			wr(8'h6E, {4'h9, c[3:0]});
			repeat (2) @(posedge core_clk);
			e = (c < 8) ? gl[c[2:0]] : (c == 9);
			#1 chk(bc[0], e);
			chk(bc[1], 1'b1);
		end
		fsync <= 1'b1;
		wr(8'h6E, 8'h9A);
		repeat (2) @(posedge core_clk);
		#1 chk(bc[1:0], 2'h3);
		wr(8'h6E, 8'h88);
		$display("t_gpio done");
	endtask
	task automatic t_alias;
		wr(8'h5E, 8'h33);
		wr(8'h6C, 8'h55);
		look(7'h2A, 1'b1, 1'b1, 7'h33, 1'b1);
		look(7'h2A, 1'b0, 1'b1, 7'h33, 1'b0);
		wr(8'h6C, 8'h00);
		look(7'h00, 1'b1, 1'b0, 7'h00, 1'b0);
		look(7'h2A, 1'b1, 1'b0, 7'h00, 1'b0);
		$display("t_alias done");
	endtask
	task automatic t_csi;
		pkt(0, 5'h00, 0, 3, 0);
		pkt(0, 5'h10, 1, 1, 1);
		pkt(0, 5'h00, 0, 3, 3);
		wr(8'h6D, 8'h40);
		pkt(0, 5'h08, 0, 3, 0);
		pkt(0, 5'h04, 0, 3, 0);
		pkt(0, 5'h02, 0, 3, 0);
		pkt(0, 5'h00, 0, 3, 3);
		wr(8'h6D, 8'h78);
		pkt(0, 5'h08, 0, 3, 3);
		pkt(0, 5'h02, 0, 3, 3);
		wr(8'h4C, 8'h20);
		wr(8'h6D, 8'hF8);
		pkt(1, 5'h00, 0, 2, 0);
		pkt(1, 5'h10, 2, 1, 0);
		pkt(1, 5'h10, 1, 1, 1);
		pkt(1, 5'h00, 0, 2, 2);
		$display("t_csi done");
	endtask
	task automatic t_raw;
		wr(8'h4C, 8'h40);
		wr(8'h6D, 8'hDB);
		pkt(2, 5'h08, 0, 2, 2);
		pkt(2, 5'h01, 0, 2, 0);
		wr(8'h6D, 8'hD3);
		pkt(2, 5'h01, 0, 2, 2);
		$display("t_raw done");
	endtask
	task automatic results;
		$display("compares %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog: a hang counts against the run
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("[ERR] %0t run did not finish", $time);
		results();
	end
	initial begin
		{rstn, reg_wr, reg_rd, i2c_addr_vld, i2c_is_write} = 5'h00;
		{reg_addr, reg_wdata, i2c_addr} = 23'h000000;
		fsync = 1'b1;
		{num_errors, n_compared, beats} = '0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_regs();
		wr(8'h4C, 8'h10);
		t_gpio();
		t_alias();
		t_csi();
		t_raw();
		results();
	end
endmodule
`default_nettype wire
